// ### shared/wwd_pkg.sv
/*
 * Constants, types and helper functions for the windowed watchdog.
 * Assumes a 50 MHz ref_clk and a core that drives the watchdog inputs
 * synchronously to that clock.
 */
// Contract
// - Period select chooses 1 ms to 256 s
// - Any reset restores the two second period
// - Windowed clear outside window resets device
// - Config window field, else register when 111
// - Violation resets and clears violation flag
// - Listed events clear the watchdog counter
// - Windowed clear needs prior control 0 read
// - Counting restarts from zero in Sleep
// - Counter held zero while startup timer runs
// - Time-out in Sleep wakes, no reset
// - Time-out updates status and reset flags
// - Enable field 11, 10, 01 decoding
// - Time base from low or mid oscillator
package wwd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clocking and time base
    localparam int unsigned REF_CLK_HZ    = 50_000_000;
    localparam int unsigned LF_OSC_HZ     = 31_000;
    localparam int unsigned MF_OSC_HZ     = 31_250;
    localparam int unsigned LF_DIV        = REF_CLK_HZ / LF_OSC_HZ;
    localparam int unsigned MF_DIV        = REF_CLK_HZ / MF_OSC_HZ;
    localparam int unsigned PERIOD_MIN_MS = 1;
    localparam int unsigned PERIOD_MAX_S  = 256;

    localparam int          PS_W          = 5;
    localparam int          CNT_W         = 23;
    localparam logic [PS_W-1:0]  PS_MAX       = 5'h12;
    localparam logic [PS_W-1:0]  PS_DEFAULT   = 5'h0b;
    // Oscillator ticks in one nominal millisecond
    localparam logic [CNT_W:0]   TICKS_PER_MS = 24'h000020;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses) and field positions
    localparam int          ADDR_W    = 5;
    localparam logic [ADDR_W-1:0] OFS_CTL0   = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_CTL1   = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_POWER_CONTROL_REG   = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_STAT   = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQST  = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQMSK = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_COUNT  = 5'h18;

    localparam int CTL0_SEN_BIT  = 0;
    localparam int CTL0_PS_LSB   = 1;
    localparam int CTL1_WIN_LSB  = 0;
    localparam int CTL1_CS_LSB   = 4;
    localparam int POWER_CONTROL_REG_WATCHDOG_RESET_FLAG_BIT = 0;
    localparam int POWER_CONTROL_REG_WV_BIT   = 1;
    localparam int STAT_PD_BIT   = 0;
    localparam int STAT_TO_BIT   = 1;
    localparam int IRQ_W         = 3;
    localparam int IRQ_TO_BIT    = 0;
    localparam int IRQ_WV_BIT    = 1;
    localparam int IRQ_WAKE_BIT  = 2;

    localparam logic [2:0] SEL_REG    = 3'h7;
    localparam logic [2:0] WIN_FULL   = 3'h7;
    localparam logic [2:0] WIN_RESET  = 3'h7;
    localparam logic [2:0] CS_LF      = 3'h0;
    localparam logic [2:0] CS_MF      = 3'h1;
    localparam logic [2:0] CS_RESET   = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        EN_OFF    = 2'h0,
        EN_SOFT   = 2'h1,
        EN_AWAKE  = 2'h2,
        EN_ALWAYS = 2'h3
    } wwd_en_mode_t;

    typedef enum logic [1:0] {
        BS_WAIT = 2'b01,
        BS_ACK  = 2'b10
    } wwd_bus_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [2:0] effSel(input logic [2:0] cfg, input logic [2:0] reg3);
        effSel = (cfg == SEL_REG) ? reg3 : cfg;
    endfunction

    // Selects above the top code saturate at the longest period
    function automatic logic [CNT_W:0] periodLen(input logic [PS_W-1:0] ps);
        logic [PS_W-1:0] lim;
        lim = (ps > PS_MAX) ? PS_MAX : ps;
        periodLen = TICKS_PER_MS << lim;
    endfunction

    // Window of (ws+1)/8 of the period, placed at the end of the period
    function automatic logic [CNT_W:0] windowStart(input logic [PS_W-1:0] ps,
                                                   input logic [2:0] ws);
        logic [CNT_W:0] eighth;
        eighth = periodLen(ps) >> 3;
        windowStart = eighth * {{(CNT_W-2){1'b0}}, WIN_FULL - ws};
    endfunction

endpackage

// ### hdl/wwd_osc_tick.sv
/*
 * Oscillator tick source: one ref_clk pulse per cycle of the selected
 * low or mid frequency internal oscillator.
 * Assumes ref_clk at 50 MHz; the select may change at any time.
 */
`timescale 1ns/1ps
module wwd_osc_tick
    import wwd_pkg::*;
#(
    parameter int unsigned LF_DIV_P = LF_DIV,
    parameter int unsigned MF_DIV_P = MF_DIV
) (
    input  wire logic ref_clk,  // System clock
    input  wire logic reset_n,  // Asynchronous reset, active low
    input  wire logic useMid,   // High selects the mid frequency oscillator
    output logic      tick      // One-cycle pulse per oscillator cycle
);

    if (LF_DIV_P < 2 || LF_DIV_P > 65536 || MF_DIV_P < 2 || MF_DIV_P > 65536) begin : g_bad
        $error("wwd_osc_tick: divider out of range 2..65536");
    end

    logic [15:0] divCnt_r;
    logic        tick_r;

    wire [15:0] reload = useMid ? 16'(MF_DIV_P - 1) : 16'(LF_DIV_P - 1);
    wire        wrap   = (divCnt_r == 16'h0000);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_r <= 16'h0000;
            tick_r   <= 1'b0;
        end else begin
            divCnt_r <= wrap ? reload : divCnt_r - 16'h0001;
            tick_r   <= wrap;
        end
    end

    assign tick = tick_r;

endmodule // wwd_osc_tick

// ### hdl/wwd_top.sv
/*
 * Windowed watchdog with an Avalon-MM register slave, sticky event
 * status with mask and one level interrupt.
 * Assumes the core drives configuration, Sleep, start-up timer and the
 * clear instruction pulse synchronously to ref_clk.
 */
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module wwd_top
    import wwd_pkg::*;
#(
    parameter int unsigned LF_DIV_P = LF_DIV,
    parameter int unsigned MF_DIV_P = MF_DIV
) (
    input  wire logic              ref_clk,            // 50 MHz clock
    input  wire logic              reset_n,            // Power-on reset, active low
    input  wire logic [ADDR_W-1:0] avs_address,        // Byte address
    input  wire logic              avs_read,           // Read request
    input  wire logic              avs_write,          // Write request
    input  wire logic [31:0]       avs_writedata,      // Write data
    input  wire logic [3:0]        avs_byteenable,     // Lane 0 carries all fields
    output logic [31:0]            avs_readdata,       // Read data
    output logic                   avs_waitrequest,    // Low for the accepting cycle
    input  wire logic [1:0]        cfgEnableMode,      // Enable mode fuse field
    input  wire logic [2:0]        cfgWindowSize,      // Window size fuse field
    input  wire logic [2:0]        cfgClockSelect,     // Clock select fuse field
    input  wire logic              sleepMode,          // Device is in Sleep
    input  wire logic              clearWatchdogInstr, // Clear instruction pulse
    input  wire logic              oscStartupRunning,  // Start-up timer running
    output logic                   wdtResetReq,        // Watchdog reset pulse
    output logic                   wakeReq,            // Wake from Sleep pulse
    output logic                   irq                 // Level interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // State
    wwd_bus_state_t   busState_r;
    logic             waitReq_r;
    logic [31:0]      rdData_r;
    logic             swEnable_r;
    logic [PS_W-1:0]  periodSel_r;
    logic [2:0]       windowReg_r;
    logic [2:0]       clockSelReg_r;
    logic             winViolFlag_r;
    logic             wdResetFlag_r;
    logic             timeoutFlag_r;
    logic             powerdownFlag_r;
    logic [IRQ_W-1:0] irqStatus_r;
    logic [IRQ_W-1:0] irqMask_r;
    logic [CNT_W-1:0] count_r;
    logic             armed_r;
    logic             sleep_r;
    logic             internalRst_r;
    logic             wake_r;
    logic             irq_r;
    logic             oscTick;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire busReq  = avs_read | avs_write;
    wire accept  = busReq & (busState_r == BS_ACK);
    wire wrAcc   = accept & avs_write & avs_byteenable[0];
    wire rdAcc   = accept & avs_read;
    wire wrCtl0  = wrAcc & (avs_address == OFS_CTL0);
    wire wrCtl1  = wrAcc & (avs_address == OFS_CTL1);
    wire wrPcon  = wrAcc & (avs_address == OFS_POWER_CONTROL_REG);
    wire wrIrqSt = wrAcc & (avs_address == OFS_IRQST);
    wire wrIrqMk = wrAcc & (avs_address == OFS_IRQMSK);
    wire rdCtl0  = rdAcc & (avs_address == OFS_CTL0);
    wire [7:0] wd = avs_writedata[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Mode, window and time base selection
    wire wdActive = (cfgEnableMode == EN_ALWAYS)
                  | ((cfgEnableMode == EN_AWAKE) & ~sleepMode)
                  | ((cfgEnableMode == EN_SOFT) & swEnable_r);
    wire [2:0] effWin   = effSel(cfgWindowSize, windowReg_r);
    wire [2:0] effClk   = effSel(cfgClockSelect, clockSelReg_r);
    wire       windowed = (effWin != WIN_FULL);
    wire       useMid   = (effClk == CS_MF);

    wwd_osc_tick #(
        .LF_DIV_P (LF_DIV_P),
        .MF_DIV_P (MF_DIV_P)
    ) u_tick (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .useMid  (useMid),
        .tick    (oscTick)
    );

    wire [CNT_W:0]   periodTicks = periodLen(periodSel_r);
    wire [CNT_W:0]   periodM1    = periodTicks - {{CNT_W{1'b0}}, 1'b1};
    wire [CNT_W-1:0] lastCount   = periodM1[CNT_W-1:0];
    wire [CNT_W:0]   winStart    = windowStart(periodSel_r, effWin);
    wire             inWindow    = ({1'b0, count_r} >= winStart);

    ////////////////////////////////////////////////////////////////////////
    // Events
    wire clrOk      = armed_r & inWindow;
    wire clrValid   = clearWatchdogInstr & wdActive & (~windowed | clrOk);
    wire winViol    = clearWatchdogInstr & wdActive & windowed & ~clrOk;
    wire sleepEnter = sleepMode & ~sleep_r;
    wire sleepExit  = ~sleepMode & sleep_r;
    wire clearCnt   = internalRst_r | clrValid | sleepEnter | sleepExit
                    | ~wdActive | oscStartupRunning | wrCtl0 | wrCtl1;
    wire timeout    = wdActive & oscTick & (count_r == lastCount) & ~clearCnt;
    wire awakeRst   = (timeout & ~sleepMode) | winViol;
    wire sleepWake  = timeout & sleepMode;
    wire [IRQ_W-1:0] irqSet = {sleepWake, winViol, timeout};
    wire [IRQ_W-1:0] irqClr = wrIrqSt ? wd[IRQ_W-1:0] : {IRQ_W{1'b0}};

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    wire [31:0] rdMux =
        (avs_address == OFS_CTL0)   ? 32'({periodSel_r, swEnable_r}) :
        (avs_address == OFS_CTL1)   ? 32'({clockSelReg_r, 1'b0, windowReg_r}) :
        (avs_address == OFS_POWER_CONTROL_REG)   ? 32'({winViolFlag_r, wdResetFlag_r}) :
        (avs_address == OFS_STAT)   ? 32'({timeoutFlag_r, powerdownFlag_r}) :
        (avs_address == OFS_IRQST)  ? 32'(irqStatus_r) :
        (avs_address == OFS_IRQMSK) ? 32'(irqMask_r) :
        (avs_address == OFS_COUNT)  ? 32'(count_r) : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then accept with waitrequest low
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busState_r <= BS_WAIT;
            waitReq_r  <= 1'b1;
            rdData_r   <= 32'h00000000;
        end else begin
            case (busState_r)
                BS_WAIT: begin
                    if (busReq) begin
                        busState_r <= BS_ACK;
                        waitReq_r  <= 1'b0;
                        rdData_r   <= avs_read ? rdMux : 32'h00000000;
                    end
                end
                BS_ACK: begin
                    busState_r <= BS_WAIT;
                    waitReq_r  <= 1'b1;
                end
                default: begin
                    busState_r <= BS_WAIT;
                    waitReq_r  <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers; a watchdog reset restores them like any reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            swEnable_r    <= 1'b0;
            periodSel_r   <= PS_DEFAULT;
            windowReg_r   <= WIN_RESET;
            clockSelReg_r <= CS_RESET;
        end else if (internalRst_r) begin
            swEnable_r    <= 1'b0;
            periodSel_r   <= PS_DEFAULT;
            windowReg_r   <= WIN_RESET;
            clockSelReg_r <= CS_RESET;
        end else begin
            if (wrCtl0) begin
                swEnable_r  <= wd[CTL0_SEN_BIT];
                periodSel_r <= wd[CTL0_PS_LSB +: PS_W];
            end
            if (wrCtl1) begin
                windowReg_r   <= wd[CTL1_WIN_LSB +: 3];
                clockSelReg_r <= wd[CTL1_CS_LSB +: 3];
            end
        end
    end

    // Arming read wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            armed_r <= 1'b0;
        end else begin
            armed_r <= rdCtl0 | (armed_r & ~clearWatchdogInstr & ~internalRst_r);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= {CNT_W{1'b0}};
        end else if (clearCnt | timeout) begin
            count_r <= {CNT_W{1'b0}};
        end else if (oscTick) begin
            count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags. Hardware events beat software sets in the same cycle.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            winViolFlag_r   <= 1'b1;
            wdResetFlag_r   <= 1'b1;
            timeoutFlag_r   <= 1'b1;
            powerdownFlag_r <= 1'b1;
        end else begin
            if (winViol) begin
                winViolFlag_r <= 1'b0;
            end else if (wrPcon & wd[POWER_CONTROL_REG_WV_BIT]) begin
                winViolFlag_r <= 1'b1;
            end
            if (timeout) begin
                wdResetFlag_r <= 1'b0;
            end else if (wrPcon & wd[POWER_CONTROL_REG_WATCHDOG_RESET_FLAG_BIT]) begin
                wdResetFlag_r <= 1'b1;
            end
            if (timeout) begin
                timeoutFlag_r   <= 1'b0;
                powerdownFlag_r <= ~sleepMode;
            end else if (clrValid) begin
                timeoutFlag_r   <= 1'b1;
                powerdownFlag_r <= 1'b1;
            end else if (sleepEnter) begin
                powerdownFlag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqStatus_r <= {IRQ_W{1'b0}};
            irqMask_r   <= {IRQ_W{1'b0}};
            irq_r       <= 1'b0;
        end else begin
            irqStatus_r <= (irqStatus_r & ~irqClr) | irqSet;
            irqMask_r   <= wrIrqMk ? wd[IRQ_W-1:0] : irqMask_r;
            irq_r       <= |(irqStatus_r & irqMask_r);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sleep_r       <= 1'b0;
            internalRst_r <= 1'b0;
            wake_r        <= 1'b0;
        end else begin
            sleep_r       <= sleepMode;
            internalRst_r <= awakeRst;
            wake_r        <= sleepWake;
        end
    end

    assign avs_readdata    = rdData_r;
    assign avs_waitrequest = waitReq_r;
    assign wdtResetReq     = internalRst_r;
    assign wakeReq         = wake_r;
    assign irq             = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    chk_period_range: assert property (
        periodTicks >= TICKS_PER_MS && periodTicks <= (TICKS_PER_MS << PS_MAX))
        else $error("period out of range");
    chk_default_period: assert property (
        internalRst_r |=> periodSel_r == PS_DEFAULT && !swEnable_r)
        else $error("period not restored after reset");
    chk_window_early: assert property (
        clearWatchdogInstr && wdActive && windowed && !inWindow |=> wdtResetReq)
        else $error("early windowed clear did not reset");
    chk_window_source: assert property (
        cfgWindowSize != SEL_REG |-> effWin == cfgWindowSize)
        else $error("window size source wrong");
    chk_viol_flag: assert property (
        winViol |=> !winViolFlag_r && wdtResetReq)
        else $error("violation flag not cleared");
    chk_clear_events: assert property (
        sleepEnter || sleepExit || wrCtl0 || wrCtl1 || clrValid |=> count_r == '0)
        else $error("counter not cleared");
    chk_unarmed_clear: assert property (
        clearWatchdogInstr && wdActive && windowed && !armed_r |=> wdtResetReq)
        else $error("unarmed clear not a violation");
    chk_ost_hold: assert property (
        oscStartupRunning [*2] |-> count_r == '0)
        else $error("counter moved during start-up");
    chk_sleep_wake: assert property (
        sleepMode && timeout |=> wakeReq && !wdtResetReq)
        else $error("sleep time-out handled wrong");
    chk_timeout_flags: assert property (
        timeout |=> !timeoutFlag_r && !wdResetFlag_r && (wdtResetReq || wakeReq))
        else $error("time-out flags not updated");
    chk_awake_off: assert property (
        cfgEnableMode == EN_AWAKE && sleepMode && $past(sleepMode) |-> count_r == '0)
        else $error("awake-only mode counted in Sleep");
    chk_mode_off: assert property (
        cfgEnableMode == EN_OFF && $past(cfgEnableMode) == EN_OFF |-> count_r == '0)
        else $error("disabled watchdog counted");
    chk_awake_reset: assert property (
        $rose(wdtResetReq) && !$past(winViol) |-> $past(count_r) == $past(lastCount))
        else $error("reset not at period end");

    cov_sleep_timeout: cover property (sleepWake);
    cov_window_viol: cover property (winViol);
    cov_windowed_clear: cover property (clrValid && windowed);

endmodule // wwd_top

// ### test/wwd_core_model.sv
/* Core model: the Sleep and clear-instruction side of the watchdog.
   Assumes the bench pulses sleepGo and clearGo for one ref_clk cycle. */
`timescale 1ns/1ps
module wwd_core_model (
    input  wire logic ref_clk,            // Clock
    input  wire logic reset_n,            // Reset, active low
    input  wire logic sleepGo,            // Enter Sleep
    input  wire logic clearGo,            // Issue one clear
    input  wire logic wakeReq,            // Wake pulse from watchdog
    output logic      sleepMode,          // Core asleep
    output logic      clearWatchdogInstr  // Clear pulse
);
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sleepMode          <= 1'b0;
            clearWatchdogInstr <= 1'b0;
        end else begin
            // Only the watchdog ends Sleep; no other wake source exists here
            if (wakeReq)
                sleepMode <= 1'b0;
            else if (sleepGo)
                sleepMode <= 1'b1;
            clearWatchdogInstr <= clearGo;
        end
    end
endmodule // wwd_core_model

// ### test/wwd_top_tb_top.sv
/* Self-checking bench for wwd_top over its Avalon-MM slave.
   Assumes the divider parameters are shortened to 4 and 3. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h seen %h", nm, e, g); end end
module wwd_top_tb_top;
    import wwd_pkg::*;
    logic ref_clk = 0, reset_n = 0, rd = 0, wr = 0, sleepGo = 0, clearGo = 0, osr = 0;
    logic [4:0] adr = 0;
    logic [31:0] wdat = 0, rdat, q;
    logic waitReq, sleepMode, clr, rstReq, wakeReq, irq;
    logic [1:0] cfgEn = 2'h2;
    logic [2:0] cfgWin = 3'h7, cfgCs = 3'h0;
    int err_total = 0, checks_done = 0, rstCnt = 0, wakeCnt = 0, cycles = 0, n, r0;
    always #10 ref_clk = ~ref_clk;
    wwd_top #(.LF_DIV_P(4), .MF_DIV_P(3)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
        .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(waitReq),
        .cfgEnableMode(cfgEn), .cfgWindowSize(cfgWin), .cfgClockSelect(cfgCs),
        .sleepMode(sleepMode), .clearWatchdogInstr(clr), .oscStartupRunning(osr),
        .wdtResetReq(rstReq), .wakeReq(wakeReq), .irq(irq));
    wwd_core_model u_core (.ref_clk(ref_clk), .reset_n(reset_n), .sleepGo(sleepGo),
        .clearGo(clearGo), .wakeReq(wakeReq), .sleepMode(sleepMode),
        .clearWatchdogInstr(clr));
    always @(posedge ref_clk) begin
        if (rstReq === 1'b1) rstCnt <= rstCnt + 1;
        if (wakeReq === 1'b1) wakeCnt <= wakeCnt + 1;
        cycles <= cycles + 1;
        // Whole run needs well under this many cycles
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= {24'h0, d};
        do @(posedge ref_clk); while (waitReq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        acc(1'b0, a, 8'h00);
        `CHK($sformatf("reg %h", a), e, q)
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic pulse(input logic s);
        if (s) sleepGo <= 1'b1;
        else clearGo <= 1'b1;
        @(posedge ref_clk);
        sleepGo <= 1'b0;
        clearGo <= 1'b0;
    endtask
    // Cycles until the next reset or wake pulse, or the limit
    task automatic run(input int lim);
        int w0;
        r0 = rstCnt;
        w0 = wakeCnt;
        n = 0;
        while (rstCnt == r0 && wakeCnt == w0 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(2);
        reset_n <= 1'b1;
        rdc(OFS_CTL0, 32'h16);
        rdc(OFS_CTL1, 32'h07);
        rdc(OFS_POWER_CONTROL_REG, 32'h03);
        rdc(OFS_STAT, 32'h03);
        rdc(5'h1c, 32'h0);
        acc(1, OFS_IRQMSK, 8'h07);
        acc(1, OFS_CTL0, 8'h00);
        run(400);
        `CHK("lf period", 1'b1, n >= 120 && n <= 140)
        `CHK("awake reset", r0 + 1, rstCnt)
        rdc(OFS_STAT, 32'h01);
        rdc(OFS_POWER_CONTROL_REG, 32'h02);
        rdc(OFS_CTL0, 32'h16);
        rdc(OFS_IRQST, 32'h01);
        `CHK("irq set", 1'b1, irq)
        acc(1, OFS_IRQST, 8'h01);
        tick(2);
        `CHK("irq clr", 1'b0, irq)
        cfgCs <= 3'h1;
        acc(1, OFS_CTL0, 8'h00);
        run(400);
        `CHK("mf period", 1'b1, n >= 90 && n <= 106)
        cfgCs <= 3'h7;
        acc(1, OFS_CTL1, 8'h17);
        acc(1, OFS_CTL0, 8'h00);
        run(400);
        `CHK("reg clock", 1'b1, n >= 90 && n <= 106)
        cfgCs <= 3'h0;
        acc(1, OFS_CTL0, 8'h00);
        r0 = rstCnt;
        repeat (6) begin
            tick(60);
            pulse(0);
        end
        `CHK("clears hold", r0, rstCnt)
        cfgEn <= 2'h0;
        acc(1, OFS_CTL0, 8'h01);
        tick(300);
        rdc(OFS_COUNT, 32'h0);
        cfgEn <= 2'h1;
        acc(1, OFS_CTL0, 8'h01);
        run(400);
        `CHK("soft reset", r0 + 1, rstCnt)
        tick(200);
        rdc(OFS_COUNT, 32'h0);
        cfgEn <= 2'h2;
        osr <= 1'b1;
        acc(1, OFS_CTL0, 8'h00);
        tick(300);
        rdc(OFS_COUNT, 32'h0);
        osr <= 1'b0;
        run(400);
        `CHK("ost reset", r0 + 1, rstCnt)
        cfgWin <= 3'h3;
        acc(1, OFS_POWER_CONTROL_REG, 8'h03);
        acc(1, OFS_CTL0, 8'h00);
        rdc(OFS_CTL0, 32'h00);
        pulse(0);
        run(20);
        `CHK("early clear", r0 + 1, rstCnt)
        rdc(OFS_POWER_CONTROL_REG, 32'h01);
        acc(1, OFS_POWER_CONTROL_REG, 8'h03);
        rdc(OFS_POWER_CONTROL_REG, 32'h03);
        acc(1, OFS_CTL0, 8'h00);
        tick(80);
        rdc(OFS_CTL0, 32'h00);
        pulse(0);
        run(20);
        `CHK("in window", r0, rstCnt)
        tick(60);
        pulse(0);
        run(20);
        `CHK("unarmed", r0 + 1, rstCnt)
        cfgWin <= 3'h7;
        acc(1, OFS_CTL1, 8'h03);
        acc(1, OFS_CTL0, 8'h00);
        rdc(OFS_CTL0, 32'h00);
        pulse(0);
        run(20);
        `CHK("reg window", r0 + 1, rstCnt)
        rdc(OFS_CTL1, 32'h07);
        cfgEn <= 2'h3;
        acc(1, OFS_IRQST, 8'h07);
        acc(1, OFS_IRQMSK, 8'h04);
        acc(1, OFS_CTL0, 8'h00);
        pulse(1);
        run(400);
        `CHK("sleep no reset", r0, rstCnt)
        `CHK("sleep period", 1'b1, n >= 120 && n <= 140)
        tick(2);
        `CHK("awake again", 1'b0, sleepMode)
        `CHK("wake irq", 1'b1, irq)
        rdc(OFS_STAT, 32'h00);
        // Awake-only mode: Sleep stops the count and nothing wakes the core
        cfgEn <= 2'h2;
        pulse(1);
        tick(200);
        rdc(OFS_COUNT, 32'h0);
        report_and_stop();
    end
endmodule // wwd_top_tb_top
